/* chsf_pkg.sv */
// Notes on behaviour
// (R1) Status1 bits 7,6: input overvoltage, input valid
// (R2) Status1 bit 5: input current limited
// (R3) Status1 bit 4: die thermal limiting active
// (R4) Status1 bit 3: end-of-charge latches, holds
// (R5) Status1 bits 2:0: charger state code
// (R6) Status2 bits 7:5: thermistor zone code
// (R7) Status2 bit 4: four consecutive peak limits
// (R8) Status2 bits 2:0: battery level code
// (R9) Fault bit 3: battery short, resets 0
// (R10) Fault bit 2: peak current fault, resets 0
// (R11) Fault bits 1,0: low/high overtemperature latches
// (R12) Writing one clears fault; power cycle too
// (R13) Short timeout code: 1..180 seconds, default 30
// (R14) Short threshold 2.0 V + 0.1 V/step, default 2.4
// (R15) Short fault after full timeout below threshold
// (R16) Reserved bits read zero, ignore writes
package chsf_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_STATUS_FIRST = 8'h0B;
  localparam logic [7:0] ADDR_STATUS_SECOND = 8'h0C;
  localparam logic [7:0] ADDR_FAULT_FLAGS = 8'h0D;
  localparam logic [7:0] ADDR_SHORT_CONFIG = 8'h10;
  // Field positions
  localparam int OV_BIT = 7;
  localparam int VALID_BIT = 6;
  localparam int ILIM_BIT = 5;
  localparam int THERM_BIT = 4;
  localparam int CHARGE_COMPLETE_LATCH_BIT = 3;
  localparam int IPK_BIT = 4;
  localparam int FAULT_SHORT_BIT = 3;
  localparam int FAULT_PEAK_BIT = 2;
  localparam int FAULT_TLOW_BIT = 1;
  localparam int FAULT_THIGH_BIT = 0;
  // Writable masks of the fault and config registers
  localparam logic [7:0] FAULT_MASK = 8'h0F;
  localparam logic [7:0] CONFIG_MASK = 8'hE7;
  // Reset values
  localparam logic [2:0] TIMEOUT_SEL_RESET = 3'h4;
  localparam logic [2:0] VOLTAGE_SEL_RESET = 3'h4;
  localparam logic [3:0] FAULT_RESET = 4'h0;
  // Charger state code for end of charge
  localparam logic [2:0] STATE_COMPLETE = 3'h4;
  // Consecutive peak limits before status/fault
  localparam logic [2:0] PEAK_RUN_COUNT = 3'h4;
  // Clock rate and derived one-second count
  localparam longint CLK_HZ = 20_000_000;
  localparam int SECOND_S = 1;
  localparam int SECOND_CYCLES = int'(CLK_HZ * SECOND_S);
  // Short threshold base and step in millivolts
  localparam logic [11:0] SHORT_BASE_MV = 12'h7D0;
  localparam logic [11:0] SHORT_STEP_MV = 12'h064;

  // Analog-side inputs arriving from comparators and converters
  typedef struct packed {
    logic over_voltage;      // Input above overvoltage level
    logic input_valid;       // Input above valid level
    logic current_limited;   // Blocking transistor limits current
    logic thermal_limited;   // Die temperature limits charging
    logic [2:0] charge_state; // Charger state code
    logic [2:0] therm_zone;  // Thermistor zone code
    logic peak_hit;          // Peak current limit reached this cycle
    logic peak_normal;       // Switching cycle ended without limit
    logic [2:0] batt_level;  // Battery level code
    logic over_temp_low;     // Lower overtemperature comparator
    logic over_temp_high;    // Higher overtemperature comparator
    logic [11:0] sense_mv;   // Battery sense voltage, millivolts
  } chsf_analog_t;

  // Detector states for the battery short timer
  typedef enum logic [1:0] {SHORT_IDLE, SHORT_TIMING, SHORT_TRIPPED} chsf_short_t;

  // Timeout in seconds for a timeout code
  function automatic logic [7:0] timeout_s(input logic [2:0] code);
    case (code)
      3'h0: timeout_s = 8'h01;
      3'h1: timeout_s = 8'h02;
      3'h2: timeout_s = 8'h04;
      3'h3: timeout_s = 8'h0A;
      3'h4: timeout_s = 8'h1E;
      3'h5: timeout_s = 8'h3C;
      3'h6: timeout_s = 8'h78;
      default: timeout_s = 8'hB4;
    endcase
  endfunction : timeout_s

  // Threshold in millivolts for a voltage code
  function automatic logic [11:0] threshold_mv(input logic [2:0] code);
    threshold_mv = 12'(SHORT_BASE_MV + SHORT_STEP_MV * {9'h000, code});
  endfunction : threshold_mv
endpackage : chsf_pkg

/* chsf_regs.sv */
`timescale 1ns/1ns
module chsf_regs #(
  parameter int SECOND_CYCLES = chsf_pkg::SECOND_CYCLES // Cycles per second
) (
  input wire logic mclk, // 20 MHz clock
  input wire logic reset, // Synchronous reset, power cycle
  input wire chsf_pkg::chsf_analog_t analog_in, // Analog-side flags
  input wire logic [7:0] reg_addr, // Register address
  input wire logic reg_wr, // Write strobe
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata_q, // Read data, one cycle after strobe
  output logic [2:0] short_timeout_select, // Selected timeout code
  output logic [2:0] short_voltage_select // Selected threshold code
);
  // Two-flop synchroniser for the analog side
  // Each comparator level is asynchronous to mclk, so nothing but the
  // second stage may read the first; all status and fault logic below
  // works on the second stage only, two edges behind the pins
  chsf_pkg::chsf_analog_t sync1_q; // First stage, read only by second
  chsf_pkg::chsf_analog_t sync2_q; // Safe copy

  // Synchroniser stages; a power cycle clears both so no stale level
  // survives into the edge detectors below
  always_ff @(posedge mclk) begin
    if (reset) begin
      // Both stages start at the idle level of every comparator
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      // Shift the pin levels in
      sync1_q <= analog_in;
      sync2_q <= sync1_q;
    end
  end

  // Register state
  // Every flop below has a _d partner computed in one always_comb and
  // registered, unchanged, in the matching always_ff
  logic charge_complete_latch_q, charge_complete_latch_d; // End-of-charge latch
  logic [2:0] peak_run_q, peak_run_d; // Consecutive peak limit count
  logic peak_prev_q, peak_prev_d; // Previous peak hit level
  logic peak_current_status_q, peak_current_status_d; // Peak current status
  logic [3:0] fault_q, fault_d; // Latched faults
  logic [2:0] tsel_q, tsel_d; // Timeout code
  logic [2:0] vsel_q, vsel_d; // Threshold code
  logic [7:0] rdata_d; // Next read data
  logic tlow_prev_q, tlow_prev_d; // Previous low overtemp level
  logic thigh_prev_q, thigh_prev_d; // Previous high overtemp level
  // Short detector state
  // The prescaler divides mclk down to one-second ticks and the seconds
  // counter compares against the decoded timeout; 25 bits hold one
  // second at the full 20 MHz rate
  chsf_pkg::chsf_short_t short_q, short_d; // Detector state
  logic [24:0] pres_q, pres_d; // One-second prescaler
  logic [7:0] secs_q, secs_d; // Elapsed seconds below threshold
  // Combinational helpers, recomputed every cycle
  logic short_set; // Short fault set pulse
  logic below; // Sense voltage below threshold
  logic sec_tick; // Prescaler wrap
  logic [3:0] fault_set; // Fault set events
  logic [3:0] fault_clr; // Host clear requests
  logic wr_fault; // Write to fault register
  logic wr_cfg; // Write to config register

  // Short detector next state
  // The battery must sit below the selected threshold for the whole
  // timeout; any recovery, even for one cycle, throws the time away.
  // After a trip the detector waits for recovery so that one long short
  // raises the fault only once and a host clear is not undone at once.
  always_comb begin
    below = sync2_q.sense_mv < chsf_pkg::threshold_mv(vsel_q);
    sec_tick = pres_q == 25'(SECOND_CYCLES - 1);
    short_d = short_q;
    pres_d = pres_q;
    secs_d = secs_q;
    short_set = 1'b0;
    case (short_q)
      chsf_pkg::SHORT_IDLE: begin
        // Hold both counters at zero while armed
        pres_d = '0;
        secs_d = '0;
        if (below) begin
          // Start timing on the first low sample
          short_d = chsf_pkg::SHORT_TIMING;
        end
      end
      chsf_pkg::SHORT_TIMING: begin
        if (!below) begin // Recovered, restart
          short_d = chsf_pkg::SHORT_IDLE; // R15
        end else if (sec_tick) begin
          // One more full second spent below the threshold
          pres_d = '0;
          if (secs_q + 8'h01 >= chsf_pkg::timeout_s(tsel_q)) begin
            short_d = chsf_pkg::SHORT_TRIPPED; // R15
            short_set = 1'b1; // R9
          end else begin
            secs_d = secs_q + 8'h01;
          end
        end else begin
          // Count mclk cycles toward the next second
          pres_d = pres_q + 25'h0000001;
        end
      end
      chsf_pkg::SHORT_TRIPPED: begin
        // Fault already raised; counters hold until recovery
        if (!below) begin // Wait for recovery before rearming
          short_d = chsf_pkg::SHORT_IDLE;
        end
      end
      default: short_d = chsf_pkg::SHORT_IDLE; // Illegal code rearms
    endcase
  end

  // Short detector registers; a power cycle rearms the detector
  always_ff @(posedge mclk) begin
    if (reset) begin
      short_q <= chsf_pkg::SHORT_IDLE;
      pres_q <= '0;
      secs_q <= '0;
    end else begin
      short_q <= short_d;
      pres_q <= pres_d;
      secs_q <= secs_d;
    end
  end

  // Status, fault and config next values
  // Host strobes come from logic on mclk and are used directly; only
  // the analog levels go through the synchroniser
  always_comb begin
    wr_fault = reg_wr && reg_addr == chsf_pkg::ADDR_FAULT_FLAGS;
    wr_cfg = reg_wr && reg_addr == chsf_pkg::ADDR_SHORT_CONFIG;
    // End of charge stays latched until power cycles
    // A later drop below the recharge threshold does not clear it
    charge_complete_latch_d = charge_complete_latch_q || sync2_q.charge_state == chsf_pkg::STATE_COMPLETE; // R4
    // Count peak limits in succession; normal cycle breaks the run
    // Only a rising edge counts, so a long limit event is one hit
    peak_prev_d = sync2_q.peak_hit;
    peak_run_d = peak_run_q;
    if (sync2_q.peak_normal) begin
      peak_run_d = '0;
    end else if (sync2_q.peak_hit && !peak_prev_q && peak_run_q < chsf_pkg::PEAK_RUN_COUNT) begin
      peak_run_d = peak_run_q + 3'h1;
    end
    peak_current_status_d = peak_run_d >= chsf_pkg::PEAK_RUN_COUNT; // R7
    // Fault events
    // Overtemperature faults latch on the rising edge of the synced
    // comparator, so a clear while the die is still hot stays cleared
    tlow_prev_d = sync2_q.over_temp_low;
    thigh_prev_d = sync2_q.over_temp_high;
    fault_set = '0;
    fault_set[chsf_pkg::FAULT_SHORT_BIT] = short_set; // R9
    fault_set[chsf_pkg::FAULT_PEAK_BIT] = peak_current_status_d && !peak_current_status_q; // R10
    fault_set[chsf_pkg::FAULT_TLOW_BIT] = sync2_q.over_temp_low && !tlow_prev_q; // R11
    fault_set[chsf_pkg::FAULT_THIGH_BIT] = sync2_q.over_temp_high && !thigh_prev_q; // R11
    fault_clr = wr_fault ? reg_wdata[3:0] : 4'h0; // R12
    // Set wins over a clear in the same cycle
    // A fault that recurs while the host clears it is not lost
    fault_d = (fault_q & ~fault_clr) | fault_set; // R12
    // Config writes, reserved bits dropped
    // Bits 4:3 are never stored, so they read back zero
    tsel_d = wr_cfg ? reg_wdata[7:5] : tsel_q; // R13
    vsel_d = wr_cfg ? reg_wdata[2:0] : vsel_q; // R14
    // Read multiplexer
    // The last read value stands until the next read strobe; reads have
    // no side effects, so polling the status registers is always safe
    rdata_d = reg_rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        chsf_pkg::ADDR_STATUS_FIRST: rdata_d = {sync2_q.over_voltage, sync2_q.input_valid,
          sync2_q.current_limited, sync2_q.thermal_limited, charge_complete_latch_q,
          sync2_q.charge_state}; // R1 R2 R3 R5
        chsf_pkg::ADDR_STATUS_SECOND: rdata_d = {sync2_q.therm_zone, peak_current_status_q, 1'b0,
          sync2_q.batt_level}; // R6 R8 R16
        chsf_pkg::ADDR_FAULT_FLAGS: rdata_d = {4'h0, fault_q}; // R16
        chsf_pkg::ADDR_SHORT_CONFIG: rdata_d = {tsel_q, 2'b00, vsel_q}; // R16
        default: rdata_d = 8'h00; // Unmapped reads as zero
      endcase
    end
  end

  // Register bank flops; reset is the input power cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      charge_complete_latch_q <= 1'b0;
      peak_run_q <= '0;
      peak_prev_q <= 1'b0;
      peak_current_status_q <= 1'b0;
      fault_q <= chsf_pkg::FAULT_RESET;
      tsel_q <= chsf_pkg::TIMEOUT_SEL_RESET;
      vsel_q <= chsf_pkg::VOLTAGE_SEL_RESET;
      reg_rdata_q <= 8'h00;
      tlow_prev_q <= 1'b0;
      thigh_prev_q <= 1'b0;
    end else begin
      charge_complete_latch_q <= charge_complete_latch_d;
      peak_run_q <= peak_run_d;
      peak_prev_q <= peak_prev_d;
      peak_current_status_q <= peak_current_status_d;
      fault_q <= fault_d;
      tsel_q <= tsel_d;
      vsel_q <= vsel_d;
      reg_rdata_q <= rdata_d;
      tlow_prev_q <= tlow_prev_d;
      thigh_prev_q <= thigh_prev_d;
    end
  end

  // Config outputs come straight from their registers
  // so the analog side sees a new code one edge after the write
  assign short_timeout_select = tsel_q;
  assign short_voltage_select = vsel_q;

  // Checks
  // All checks run on mclk and stand down while the power-cycle reset
  // is high
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Status read steps
  // A read strobe to each status register, sampled at the strobe edge
  sequence s_read1;
    reg_rd && reg_addr == chsf_pkg::ADDR_STATUS_FIRST;
  endsequence
  sequence s_read2;
    reg_rd && reg_addr == chsf_pkg::ADDR_STATUS_SECOND;
  endsequence

  chk_status_first_flags: assert property (s_read1 |=> reg_rdata_q[7:4] == // R1
    {$past(sync2_q.over_voltage), $past(sync2_q.input_valid),
     $past(sync2_q.current_limited), $past(sync2_q.thermal_limited)})
    else $error("status first flags wrong");
  chk_charge_state_code: assert property (s_read1 |=> reg_rdata_q[2:0] == // R5
    $past(sync2_q.charge_state)) else $error("charge state code wrong");
  chk_charge_complete_latch_holds: assert property (charge_complete_latch_q |=> charge_complete_latch_q) // R4
    else $error("end of charge latch dropped");
  chk_status_second_fields: assert property (s_read2 |=> reg_rdata_q[7:5] == // R6
    $past(sync2_q.therm_zone) && reg_rdata_q[3] == 1'b0 &&
    reg_rdata_q[2:0] == $past(sync2_q.batt_level)) else $error("status second wrong");
  chk_peak_run_four: assert property (peak_run_q == 3'h3 && sync2_q.peak_hit && // R7
    !peak_prev_q && !sync2_q.peak_normal |=> peak_current_status_q && fault_q[2])
    else $error("peak status not set after four");
  chk_fault_set_wins: assert property (|fault_set |=> // R12
    (fault_q & $past(fault_set)) == $past(fault_set)) else $error("fault set lost");
  chk_fault_w1c_clear: assert property (wr_fault && reg_wdata[1] && // R12
    !fault_set[1] |=> !fault_q[1]) else $error("fault one-write did not clear");
  chk_thermal_latch: assert property ($rose(sync2_q.over_temp_high) |=> fault_q[0]) // R11
    else $error("high overtemperature not latched");
  chk_short_full_time: assert property ($rose(fault_q[3]) |-> $past(short_q) == // R15
    chsf_pkg::SHORT_TIMING && $past(secs_q) + 8'h01 >= chsf_pkg::timeout_s($past(tsel_q)))
    else $error("short fault before timeout");
  chk_short_recover: assert property (short_q == chsf_pkg::SHORT_TIMING && !below |=> // R15
    short_q == chsf_pkg::SHORT_IDLE ##1 secs_q == 8'h00) else $error("short timer not restarted");
  chk_config_write: assert property (wr_cfg |=> tsel_q == $past(reg_wdata[7:5]) && // R13
    vsel_q == $past(reg_wdata[2:0])) else $error("config write not stored"); // R14
  chk_reserved_zero: assert property (reg_rd && reg_addr == chsf_pkg::ADDR_SHORT_CONFIG // R16
    |=> reg_rdata_q[4:3] == 2'b00) else $error("reserved bits not zero");

  // Unmapped places read as zero
  chk_unmapped_zero: assert property (reg_rd && // R16
    reg_addr != chsf_pkg::ADDR_STATUS_FIRST && reg_addr != chsf_pkg::ADDR_STATUS_SECOND &&
    reg_addr != chsf_pkg::ADDR_FAULT_FLAGS && reg_addr != chsf_pkg::ADDR_SHORT_CONFIG
    |=> reg_rdata_q == 8'h00) else $error("unmapped read not zero");

  // Read data stands until the next read strobe; writes leave it alone
  chk_rdata_stands: assert property (!reg_rd |=> $stable(reg_rdata_q)) // R16
    else $error("read data changed without a read");

  // End of charge latch: set by the complete state and seen in the read
  chk_charge_complete_latch_sets: assert property (sync2_q.charge_state == chsf_pkg::STATE_COMPLETE |=> // R4
    charge_complete_latch_q) else $error("end of charge not latched");
  chk_charge_complete_latch_read: assert property (s_read1 |=> reg_rdata_q[3] == $past(charge_complete_latch_q)) // R4
    else $error("end of charge bit wrong in read");

  // Peak run: status readback, a normal cycle breaks the run, a rise raises the fault
  chk_ipk_read: assert property (s_read2 |=> reg_rdata_q[4] == $past(peak_current_status_q)) // R7
    else $error("peak status bit wrong in read");
  chk_peak_run_break: assert property (sync2_q.peak_normal |=> peak_run_q == 3'h0 && // R7
    !peak_current_status_q) else $error("normal cycle did not break the peak run");
  chk_peak_fault_rise: assert property ($rose(peak_current_status_q) |-> fault_q[2]) // R10
    else $error("peak fault not raised with status");

  // Low overtemperature latches like the high one
  chk_tlow_latch: assert property ($rose(sync2_q.over_temp_low) |=> fault_q[1]) // R11
    else $error("low overtemperature not latched");

  // Fault flags move only on a set event or a host one-write
  chk_fault_hold: assert property (!wr_fault && fault_set == 4'h0 |=> // R12
    $stable(fault_q)) else $error("fault flags changed with no cause");
  chk_fault_read: assert property (reg_rd && reg_addr == chsf_pkg::ADDR_FAULT_FLAGS |=> // R16
    reg_rdata_q == {4'h0, $past(fault_q)}) else $error("fault read wrong");

  // Short timer expiry: the last second below the threshold runs out
  sequence s_short_expire;
    short_q == chsf_pkg::SHORT_TIMING && below && sec_tick &&
      secs_q + 8'h01 >= chsf_pkg::timeout_s(tsel_q);
  endsequence
  chk_short_trip_sets: assert property (s_short_expire |=> short_q == // R9
    chsf_pkg::SHORT_TRIPPED && fault_q[3]) else $error("short expiry did not raise fault");
  chk_short_idle_zero: assert property (short_q == chsf_pkg::SHORT_IDLE |=> // R15
    pres_q == 25'h0000000 && secs_q == 8'h00) else $error("idle short timer not cleared");

  // Config holds between writes and reads back with reserved bits zero
  chk_config_hold: assert property (!wr_cfg |=> $stable(tsel_q) && $stable(vsel_q)) // R13
    else $error("config changed without a write"); // R14
  chk_config_read: assert property (reg_rd && reg_addr == chsf_pkg::ADDR_SHORT_CONFIG |=> // R13
    reg_rdata_q == {$past(tsel_q), 2'b00, $past(vsel_q)}) else $error("config read wrong");
endmodule : chsf_regs

/* chsf_host.sv */
`timescale 1ns/1ns
// Host side of the register port; strobes launch at the falling edge
module chsf_host (
  input wire logic mclk, // Device clock
  output logic [7:0] reg_addr, // Register address
  output logic reg_wr, // Write strobe
  output logic [7:0] reg_wdata, // Write data
  output logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata_q // Read data
);
  // Idle port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // One write; a one in a fault position acknowledges that fault
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    // Released lines show no stale value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : reg_write

  // One read; data is taken once the strobe edge has updated it
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata_q;
  endtask : reg_read
endmodule : chsf_host

/* charger_status_fault_regs_test.sv */
`timescale 1ns/1ns
// Self-checking bench for the status, fault and short-config registers
module charger_status_fault_regs_test;
  logic mclk = 1'b0; // 20 MHz clock
  logic reset = 1'b1; // Power-cycle reset
  chsf_pkg::chsf_analog_t ana = '0; // Analog-side stimulus
  logic [7:0] reg_addr; // Host address
  logic reg_wr; // Host write strobe
  logic [7:0] reg_wdata; // Host write data
  logic reg_rd; // Host read strobe
  logic [7:0] reg_rdata_q; // Read data
  logic [2:0] tsel; // Timeout code out
  logic [2:0] vsel; // Threshold code out
  int err_count = 0; // Mismatches
  int samples_checked = 0; // Comparisons
  chsf_pkg::chsf_analog_t rows_a [9]; // Table inputs
  logic [15:0] rows_e [9]; // Expected {status1, status2}

  // Clock, 50 ns period
  always #25 mclk = ~mclk;

  chsf_regs #(.SECOND_CYCLES(10)) u_chsf_regs (.mclk(mclk), .reset(reset), .analog_in(ana),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .short_timeout_select(tsel), .short_voltage_select(vsel));
  chsf_host u_chsf_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));

  // Compare and report
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Read a register and compare
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    u_chsf_host.reg_read(a, d);
    check(what, exp, d);
  endtask : expect_reg

  // Let falling edges pass
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : wait_cyc

  // Analog word with healthy battery sense
  function automatic chsf_pkg::chsf_analog_t mk(input logic [3:0] f, input logic [2:0] st,
      input logic [2:0] zn, input logic [2:0] lv);
    mk = '0;
    {mk.over_voltage, mk.input_valid, mk.current_limited, mk.thermal_limited} = f;
    mk.charge_state = st;
    mk.therm_zone = zn;
    mk.batt_level = lv;
    mk.sense_mv = 12'hBB8;
  endfunction : mk

  // One peak-limit hit, with a gap after it
  task automatic peak_pulse;
    ana.peak_hit = 1'b1;
    wait_cyc(2);
    ana.peak_hit = 1'b0;
    wait_cyc(2);
  endtask : peak_pulse

  // Verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog against a hung port
  initial begin
    repeat (3000) @(posedge mclk);
    err_count++;
    $display("BAD watchdog expected done seen timeout");
    tally_and_finish();
  end

  // Main sequence
  initial begin
    rows_a[0] = mk(4'h8, 3'h0, 3'h0, 3'h0);
    rows_a[1] = mk(4'h4, 3'h1, 3'h1, 3'h1);
    rows_a[2] = mk(4'h2, 3'h2, 3'h2, 3'h2);
    rows_a[3] = mk(4'h1, 3'h3, 3'h3, 3'h3);
    rows_a[4] = mk(4'h4, 3'h5, 3'h4, 3'h4);
    rows_a[5] = mk(4'h4, 3'h6, 3'h7, 3'h4);
    rows_a[6] = mk(4'h4, 3'h7, 3'h7, 3'h1);
    rows_a[7] = mk(4'h4, 3'h4, 3'h7, 3'h4);
    rows_a[8] = mk(4'h4, 3'h1, 3'h7, 3'h4);
    rows_e = '{16'h8000, 16'h4121, 16'h2242, 16'h1363, 16'h4584, 16'h46E4, 16'h47E1,
      16'h4CE4, 16'h49E4};
    wait_cyc(2);
    reset = 1'b0;
    // Reset values and an unmapped place
    expect_reg(chsf_pkg::ADDR_FAULT_FLAGS, 8'h00, "fault_rst");
    expect_reg(chsf_pkg::ADDR_SHORT_CONFIG, 8'h84, "cfg_rst");
    check("sel_rst", 8'h24, {2'h0, tsel, vsel});
    expect_reg(8'h55, 8'h00, "unmapped");
    $display("test reset done");
    // Status rows; the complete state latches for later rows
    for (int i = 0; i < 9; i++) begin
      ana = rows_a[i];
      wait_cyc(3);
      expect_reg(chsf_pkg::ADDR_STATUS_FIRST, rows_e[i][15:8], "status1");
      expect_reg(chsf_pkg::ADDR_STATUS_SECOND, rows_e[i][7:0], "status2");
    end
    u_chsf_host.reg_write(chsf_pkg::ADDR_STATUS_FIRST, 8'h00);
    expect_reg(chsf_pkg::ADDR_STATUS_FIRST, 8'h49, "status1_ro");
    $display("test status table done");
    // Reserved config bits and code outputs
    u_chsf_host.reg_write(chsf_pkg::ADDR_SHORT_CONFIG, 8'hFF);
    expect_reg(chsf_pkg::ADDR_SHORT_CONFIG, 8'hE7, "cfg_mask");
    check("sel_all", 8'h3F, {2'h0, tsel, vsel});
    u_chsf_host.reg_write(chsf_pkg::ADDR_SHORT_CONFIG, 8'h23);
    $display("test config done");
    // Overtemperature latches and one-write clears
    ana.over_temp_low = 1'b1;
    wait_cyc(4);
    expect_reg(chsf_pkg::ADDR_FAULT_FLAGS, 8'h02, "tlow");
    ana.over_temp_high = 1'b1;
    wait_cyc(4);
    expect_reg(chsf_pkg::ADDR_FAULT_FLAGS, 8'h03, "thigh");
    u_chsf_host.reg_write(chsf_pkg::ADDR_FAULT_FLAGS, 8'hF2);
    expect_reg(chsf_pkg::ADDR_FAULT_FLAGS, 8'h01, "clr_low");
    ana.over_temp_low = 1'b0;
    ana.over_temp_high = 1'b0;
    u_chsf_host.reg_write(chsf_pkg::ADDR_FAULT_FLAGS, 8'h01);
    expect_reg(chsf_pkg::ADDR_FAULT_FLAGS, 8'h00, "clr_high");
    $display("test thermal done");
    // Three peak hits are not enough, the fourth trips
    repeat (3) peak_pulse();
    expect_reg(chsf_pkg::ADDR_STATUS_SECOND, 8'hE4, "ipk_three");
    expect_reg(chsf_pkg::ADDR_FAULT_FLAGS, 8'h00, "peak_three");
    peak_pulse();
    expect_reg(chsf_pkg::ADDR_STATUS_SECOND, 8'hF4, "ipk_four");
    expect_reg(chsf_pkg::ADDR_FAULT_FLAGS, 8'h04, "peak_four");
    ana.peak_normal = 1'b1;
    wait_cyc(2);
    ana.peak_normal = 1'b0;
    wait_cyc(3);
    expect_reg(chsf_pkg::ADDR_STATUS_SECOND, 8'hE4, "ipk_drop");
    u_chsf_host.reg_write(chsf_pkg::ADDR_FAULT_FLAGS, 8'h04);
    expect_reg(chsf_pkg::ADDR_FAULT_FLAGS, 8'h00, "peak_clr");
    $display("test peak done");
    // Short at 2.3 V over 2 s: boundary, restart, then trip
    ana.sense_mv = 12'h8FC;
    wait_cyc(40);
    expect_reg(chsf_pkg::ADDR_FAULT_FLAGS, 8'h00, "short_edge");
    repeat (2) begin
      ana.sense_mv = 12'h8FB;
      wait_cyc(12);
      ana.sense_mv = 12'hBB8;
      wait_cyc(4);
    end
    expect_reg(chsf_pkg::ADDR_FAULT_FLAGS, 8'h00, "short_restart");
    ana.sense_mv = 12'h8FB;
    wait_cyc(30);
    expect_reg(chsf_pkg::ADDR_FAULT_FLAGS, 8'h08, "short_trip");
    ana.sense_mv = 12'hBB8;
    u_chsf_host.reg_write(chsf_pkg::ADDR_FAULT_FLAGS, 8'h08);
    expect_reg(chsf_pkg::ADDR_FAULT_FLAGS, 8'h00, "short_clr");
    $display("test short done");
    // Power cycle in mid-run clears faults, latch and config
    ana.over_temp_high = 1'b1;
    wait_cyc(4);
    ana.over_temp_high = 1'b0;
    reset = 1'b1;
    wait_cyc(2);
    reset = 1'b0;
    expect_reg(chsf_pkg::ADDR_FAULT_FLAGS, 8'h00, "fault_cycle");
    expect_reg(chsf_pkg::ADDR_SHORT_CONFIG, 8'h84, "cfg_cycle");
    expect_reg(chsf_pkg::ADDR_STATUS_FIRST, 8'h41, "latch_cycle");
    $display("test power cycle done");
    tally_and_finish();
  end
endmodule : charger_status_fault_regs_test
